// [logic/csw_builder.sv]
`timescale 1ns/1ps
module csw_builder
  import csw_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // store request
  input wire logic storeReq,
  input csw_pkg::cond_type cond,
  input csw_pkg::addrs_type addrs,
  input csw_pkg::extra_type extra,
  input wire logic [7:0] devStatIn,
  // store result
  output logic cswValid,
  output csw_pkg::csw_type csw,
  output logic malfunctionReset,
  output logic terminateOp,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData
);
  import csw_pkg::*;

  state_type state_ff, nxt_state;
  csw_type csw_ff, nxt_csw;
  logic valid_ff, nxt_valid;
  logic [31:0] rd_ff, nxt_rd;
  logic pciOnError_ff, nxt_pciOnError;
  logic lengthOnError_ff, nxt_lengthOnError;
  source_type src;
  logic [23:0] addrSel;
  chan_stat_type cs;
  logic progErr;

  // priority encoder, bottom of the list wins
  always_comb begin
    src = SRC_NONE;
    if (cond.zeroStat) src = SRC_ZERO_STAT;
    if (cond.haltCe) src = SRC_HALT_CE;
    if (cond.ifcCheck) src = SRC_IFC_CHECK;
    if (cond.pci) src = SRC_PCI;
    if (cond.chainStop) src = SRC_CHAIN_STOP;
    if (cond.suppress) src = SRC_SUPPRESS;
    if (cond.haltEnd) src = SRC_HALT_END;
    if (cond.devEnd) src = SRC_DEV_END;
    if (cond.countEnd) src = SRC_COUNT_END;
    if (cond.chainCheck) src = SRC_CHAIN_CHECK;
    if (cond.protect) src = SRC_PROTECT;
    if (cond.twoBranch) src = SRC_TWO_BRANCH;
    if (cond.badFormat) src = SRC_BAD_FORMAT;
    if (cond.badData) src = SRC_BAD_DATA;
    if (cond.badCount) src = SRC_BAD_COUNT;
    if (cond.badCode) src = SRC_BAD_CODE;
    if (cond.seqAddr) src = SRC_SEQ_ADDR;
    if (cond.brAddr) src = SRC_BR_ADDR;
    if (cond.brSpec) src = SRC_BR_SPEC;
    if (cond.byHalt) src = SRC_BY_HALT;
    if (cond.byStart) src = SRC_BY_START;
    if (cond.ctlCheck) src = SRC_CTL_CHECK;
  end

  // command address selection
  always_comb begin
    addrSel = addrs.lastUsed + WORD_STEP;
    unique case (src)
      SRC_CTL_CHECK: addrSel = ADDR_ZERO;
      SRC_BY_START, SRC_BY_HALT: addrSel = ADDR_ZERO;
      SRC_BR_SPEC, SRC_BR_ADDR: addrSel = addrs.branchAddr + WORD_STEP;
      SRC_SEQ_ADDR: addrSel = addrs.firstInvalid + WORD_STEP;
      SRC_BAD_CODE, SRC_BAD_COUNT, SRC_BAD_DATA, SRC_BAD_FORMAT,
      SRC_PROTECT: addrSel = addrs.offending + WORD_STEP;
      SRC_TWO_BRANCH: addrSel = addrs.branchAddr + WORD_STEP;
      SRC_CHAIN_CHECK, SRC_COUNT_END, SRC_DEV_END, SRC_HALT_END,
      SRC_PCI, SRC_IFC_CHECK: addrSel = addrs.lastUsed + WORD_STEP;
      SRC_SUPPRESS: addrSel = addrs.completed + WORD_STEP;
      SRC_CHAIN_STOP: addrSel = addrs.newOp + WORD_STEP;
      SRC_HALT_CE, SRC_ZERO_STAT: addrSel = ADDR_ZERO;
      SRC_NONE: addrSel = addrs.lastUsed + WORD_STEP;
      default: addrSel = addrs.lastUsed + WORD_STEP;
    endcase
  end

  // channel status bits
  always_comb begin
    progErr = cond.brSpec | cond.brAddr | cond.seqAddr | cond.badCode | cond.badCount
      | cond.badData | cond.badFormat | cond.twoBranch;
    cs = '0;
    cs.chanCtlCheck = cond.ctlCheck;
    cs.ifcCtlCheck = cond.ifcCheck;
    cs.chanDataCheck = extra.chanDataCheck | extra.dataError;
    cs.programCheck = progErr;
    cs.protectionCheck = cond.protect;
    cs.chainingCheck = cond.chainCheck;
    cs.incorrectLength = extra.lengthError
      & ((~(progErr | cond.protect | cond.chainCheck)) | lengthOnError_ff);
    if (extra.dataError & extra.earlyError & (progErr | cond.protect | cond.chainCheck)) begin
      cs.chanDataCheck = 1'b1;
    end
    cs.pci = cond.pci;
    if (extra.pciFlag & (cond.chainStop | progErr | cond.protect)) begin
      cs.pci = 1'b1;
    end
    if (extra.pciFlag & extra.startReject) begin
      cs.pci = 1'b1;
    end
    if (cond.byStart & progErr & pciOnError_ff) begin
      cs.pci = 1'b1;
    end
  end

  // store sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_csw = csw_ff;
    nxt_valid = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (storeReq) begin
          nxt_csw.cmdAddr = addrSel;
          nxt_csw.addrValid = ~cond.ctlCheck;
          // keep only when start or halt outranks everything else
          nxt_csw.addrKeep = (src == SRC_BY_START) | (src == SRC_BY_HALT);
          nxt_csw.chanStat = cs;
          nxt_csw.devStat = devStatIn;
          nxt_valid = 1'b1;
          nxt_state = cond.ctlCheck ? ST_RESET : ST_STORE;
        end
      end
      ST_STORE: nxt_state = ST_IDLE;
      ST_RESET: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_comb begin
    terminateOp = storeReq & (state_ff == ST_IDLE) & (cond.ctlCheck | cond.ifcCheck);
    malfunctionReset = (state_ff == ST_RESET);
  end

  // register port
  always_comb begin
    nxt_pciOnError = pciOnError_ff;
    nxt_lengthOnError = lengthOnError_ff;
    nxt_rd = 32'h00000000;
    if (regWrite && regAddr == OFS_SRC_CTL) begin
      nxt_pciOnError = regWrData[0];
      nxt_lengthOnError = regWrData[1];
    end
    if (regRead) begin
      unique case (regAddr)
        OFS_SRC_CTL: nxt_rd = {30'h00000000, lengthOnError_ff, pciOnError_ff};
        OFS_SRC_DEV: nxt_rd = {27'h0000000, src};
        OFS_LAST_ADDR: nxt_rd = {8'h00, csw_ff.cmdAddr};
        OFS_CHAN_STAT: nxt_rd = {22'h000000, csw_ff.addrKeep, csw_ff.addrValid,
          csw_ff.chanStat};
        OFS_DEV_STAT: nxt_rd = {24'h000000, csw_ff.devStat};
        OFS_CMD_ADDR: nxt_rd = {8'h00, addrSel};
        OFS_STATE: nxt_rd = {30'h00000000, state_ff};
        default: nxt_rd = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      csw_ff <= '0;
      valid_ff <= 1'b0;
      rd_ff <= 32'h00000000;
      pciOnError_ff <= 1'b0;
      lengthOnError_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      csw_ff <= nxt_csw;
      valid_ff <= nxt_valid;
      rd_ff <= nxt_rd;
      pciOnError_ff <= nxt_pciOnError;
      lengthOnError_ff <= nxt_lengthOnError;
    end
  end

  assign cswValid = valid_ff;
  assign csw = csw_ff;
  assign regRdData = rd_ff;

endmodule

// [logic/csw_pkg.sv]
package csw_pkg;

  localparam int ADDR_W = 24;
  localparam logic [23:0] WORD_STEP = 24'h000008;
  localparam logic [23:0] ADDR_ZERO = 24'h000000;

  localparam logic [3:0] OFS_SRC_CTL = 4'h0;
  localparam logic [3:0] OFS_SRC_DEV = 4'h1;
  localparam logic [3:0] OFS_LAST_ADDR = 4'h2;
  localparam logic [3:0] OFS_CHAN_STAT = 4'h3;
  localparam logic [3:0] OFS_DEV_STAT = 4'h4;
  localparam logic [3:0] OFS_CMD_ADDR = 4'h5;
  localparam logic [3:0] OFS_STATE = 4'h6;

  localparam logic [15:0] CHAN_STAT_RST = 16'h0000;
  localparam logic [7:0] DEV_STAT_RST = 8'h00;

  typedef enum logic [4:0] {
    SRC_NONE = 5'h00,
    SRC_CTL_CHECK = 5'h01,
    SRC_BY_START = 5'h02,
    SRC_BY_HALT = 5'h03,
    SRC_BR_SPEC = 5'h04,
    SRC_BR_ADDR = 5'h05,
    SRC_SEQ_ADDR = 5'h06,
    SRC_BAD_CODE = 5'h07,
    SRC_BAD_COUNT = 5'h08,
    SRC_BAD_DATA = 5'h09,
    SRC_BAD_FORMAT = 5'h0a,
    SRC_TWO_BRANCH = 5'h0b,
    SRC_PROTECT = 5'h0c,
    SRC_CHAIN_CHECK = 5'h0d,
    SRC_COUNT_END = 5'h0e,
    SRC_DEV_END = 5'h0f,
    SRC_HALT_END = 5'h10,
    SRC_SUPPRESS = 5'h11,
    SRC_CHAIN_STOP = 5'h12,
    SRC_PCI = 5'h13,
    SRC_IFC_CHECK = 5'h14,
    SRC_HALT_CE = 5'h15,
    SRC_ZERO_STAT = 5'h16
  } source_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STORE = 2'b01,
    ST_RESET = 2'b10
  } state_type;

  typedef struct packed {
    logic ctlCheck;
    logic byStart;
    logic byHalt;
    logic brSpec;
    logic brAddr;
    logic seqAddr;
    logic badCode;
    logic badCount;
    logic badData;
    logic badFormat;
    logic twoBranch;
    logic protect;
    logic chainCheck;
    logic countEnd;
    logic devEnd;
    logic haltEnd;
    logic suppress;
    logic chainStop;
    logic pci;
    logic ifcCheck;
    logic haltCe;
    logic zeroStat;
  } cond_type;

  typedef struct packed {
    logic [23:0] lastUsed;
    logic [23:0] offending;
    logic [23:0] branchAddr;
    logic [23:0] firstInvalid;
    logic [23:0] completed;
    logic [23:0] newOp;
  } addrs_type;

  typedef struct packed {
    logic pciFlag;
    logic dataError;
    logic lengthError;
    logic startReject;
    logic earlyError;
    logic chanDataCheck;
  } extra_type;

  typedef struct packed {
    logic pci;
    logic incorrectLength;
    logic programCheck;
    logic protectionCheck;
    logic chanDataCheck;
    logic chanCtlCheck;
    logic ifcCtlCheck;
    logic chainingCheck;
  } chan_stat_type;

  typedef struct packed {
    logic [23:0] cmdAddr;
    logic addrValid;
    logic addrKeep;
    chan_stat_type chanStat;
    logic [7:0] devStat;
  } csw_type;

endpackage

// [test/dev_status_model.sv]
`timescale 1ns/1ps
module dev_status_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // status to present
  input wire logic present,
  input wire logic [7:0] flags,
  // status byte toward the channel
  output logic [7:0] statusByte
);
  logic [7:0] nxt_status;
  logic [7:0] status_ff;
  always_comb begin
    // byte is meaningless while nothing is presented, so keep it moving
    nxt_status = ~status_ff;
    if (present) begin
      nxt_status = flags;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_ff <= 8'h00;
    end else begin
      status_ff <= nxt_status;
    end
  end
  assign statusByte = status_ff;
endmodule

// [test/csw_builder_sva.sv]
`timescale 1ns/1ps
module csw_builder_sva
  import csw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic storeReq,
  input csw_pkg::cond_type cond,
  input csw_pkg::addrs_type addrs,
  input wire logic [7:0] devStatIn,
  input wire logic cswValid,
  input csw_pkg::csw_type csw,
  input wire logic malfunctionReset,
  input wire logic terminateOp
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic take;
  assign take = storeReq && !cswValid;
  a_store_answer: assert property (take |=> cswValid)
    else $error("no status word after store");
  a_valid_pulse: assert property (cswValid |=> !cswValid)
    else $error("valid longer than one cycle");
  a_default_addr: assert property (take && cond == '0 |=>
    csw.cmdAddr == $past(addrs.lastUsed) + WORD_STEP) else $error("default address wrong");
  a_zero_addr: assert property (take && $onehot(cond) && cond.zeroStat |=>
    csw.cmdAddr == ADDR_ZERO) else $error("zero address expected");
  a_ctl_first: assert property (take && cond.ctlCheck |=>
    !csw.addrValid && csw.chanStat.chanCtlCheck) else $error("control check not shown");
  a_halt_keep: assert property (take && cond.byHalt && !cond.ctlCheck |=> csw.addrKeep)
    else $error("halt store changes address");
  a_branch_addr: assert property (take && cond.brAddr && !(|cond[21:18]) |=>
    csw.cmdAddr == $past(addrs.branchAddr) + WORD_STEP) else $error("branch address wrong");
  a_term_now: assert property (take && (cond.ctlCheck || cond.ifcCheck) |-> terminateOp)
    else $error("no termination on malfunction");
  a_malf_reset: assert property (take && cond.ctlCheck |=> malfunctionReset)
    else $error("no malfunction reset");
  a_dev_copy: assert property (take |=> csw.devStat == $past(devStatIn))
    else $error("device status altered");
  c_ctl: cover property (take && cond.ctlCheck);
  c_multi: cover property (take && $countones(cond) > 1);
  c_malf: cover property (malfunctionReset);
endmodule
bind csw_builder csw_builder_sva chk (.sys_clk(sys_clk), .rst(rst), .storeReq(storeReq),
  .cond(cond), .addrs(addrs), .devStatIn(devStatIn), .cswValid(cswValid), .csw(csw),
  .malfunctionReset(malfunctionReset), .terminateOp(terminateOp));

// [test/test_channel_status_word_builder.sv]
`timescale 1ns/1ps
module test_channel_status_word_builder;
  import csw_pkg::*;
  logic sys_clk, rst, storeReq, regWrite, regRead, present, cswValid, malfunctionReset, terminateOp;
  cond_type cond;
  addrs_type addrs;
  extra_type extra;
  csw_type csw;
  logic [7:0] devStatIn, flags;
  logic [3:0] regAddr;
  logic [31:0] regWrData, regRdData;
  int err_total = 0;
  int tests_run = 0;
  // address slot per condition, ctlCheck first; 0 means zero field
  localparam string KIND = "0003342222321111561100";
  csw_builder uut (.sys_clk(sys_clk), .rst(rst), .storeReq(storeReq), .cond(cond), .addrs(addrs),
    .extra(extra), .devStatIn(devStatIn), .cswValid(cswValid), .csw(csw),
    .malfunctionReset(malfunctionReset), .terminateOp(terminateOp), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));
  dev_status_model dev (.sys_clk(sys_clk), .rst(rst), .present(present), .flags(flags),
    .statusByte(devStatIn));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      err_total++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic store(input cond_type c, input extra_type x, input logic [7:0] f, output logic t);
    flags <= f;
    present <= 1'b1;
    @(posedge sys_clk);
    cond <= c;
    extra <= x;
    storeReq <= 1'b1;
    #1 t = terminateOp;
    @(posedge sys_clk);
    storeReq <= 1'b0;
    present <= 1'b0;
    #1 check(cswValid, 1'b1);
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask
  initial begin
    logic [31:0] rd;
    logic tOp;
    int p;
    int sb[5] = '{15, 10, 9, 4, 20};
    logic [7:0] xv[5] = '{8'h12, 8'h00, 8'h00, 8'h20, 8'h24};
    logic [7:0] mk[5] = '{8'h28, 8'h10, 8'h01, 8'h80, 8'h80};
    rst = 1'b1;
    storeReq = 1'b0;
    cond = '0;
    extra = '0;
    flags = 8'h00;
    present = 1'b0;
    regAddr = 4'h0;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    addrs = {24'h001000, 24'h002000, 24'h003000, 24'h004000, 24'h005000, 24'h006000};
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // each condition alone, then with every lower-ranked one beside it
    for (int i = 0; i < 44; i++) begin
      p = 21 - i / 2;
      store((i % 2) ? cond_type'((22'h1 << (p + 1)) - 22'h1) : cond_type'(22'h1 << p),
        '0, 8'(i), tOp);
      check(csw.cmdAddr, (KIND[i/2] == "0") ? 24'h0 : 24'((KIND[i/2] - "0") * 24'h1000 + 8));
      check(csw.devStat, 8'(i));
      check(csw.addrValid, p != 21);
      check(csw.addrKeep, p == 20 || p == 19);
      check(csw.chanStat.chanCtlCheck, p == 21);
      check(tOp, p == 21 || p == 2 || ((i % 2) == 1 && p > 2));
      check(malfunctionReset, p == 21);
    end
    reg_read(4'h4, rd);
    check(rd, 32'h2b);
    reg_read(4'hf, rd);
    check(rd, 32'h0);
    reg_write(4'h0, 32'h3);
    reg_read(4'h0, rd);
    check(rd, 32'h3);
    store('0, '0, 8'h00, tOp);
    check(csw.cmdAddr, 24'h001008);
    reg_read(4'h2, rd);
    check(rd, 32'h00001008);
    // status bits that travel together
    for (int k = 0; k < 5; k++) begin
      store(cond_type'(22'h1 << sb[k]), extra_type'(xv[k][5:0]), 8'h00, tOp);
      check(csw.chanStat & mk[k], mk[k]);
    end
    // start with a first-word error, no flag: both config bits are set
    store(cond_type'(22'h108000), extra_type'(6'h08), 8'h00, tOp);
    check(csw.chanStat & 8'he0, 8'he0);
    stop_test();
  end
endmodule
